// [hw/rsa_defs.svh]
// Offsets, fields and reset values of the round/subtract unit
`ifndef RSA_DEFS_SVH
`define RSA_DEFS_SVH
// Register byte offsets
`define RSA_OFF_CMD 12'h000
`define RSA_OFF_MEM0 12'h004
`define RSA_OFF_MEM1 12'h008
`define RSA_OFF_IMM 12'h00c
`define RSA_OFF_GR0 12'h010
`define RSA_OFF_GR5 12'h024
`define RSA_OFF_FLAG 12'h028
`define RSA_OFF_IST 12'h02c
`define RSA_OFF_IMSK 12'h030
// Command word fields
`define RSA_CMD_OP_LSB 0
`define RSA_CMD_R1_LSB 4
`define RSA_CMD_R2_LSB 10
// One-hot register selects, register indices and select masks
`define RSA_SEL_I 6'h01
`define RSA_SEL_J 6'h02
`define RSA_SEL_K 6'h04
`define RSA_SEL_E 6'h08
`define RSA_SEL_A 6'h10
`define RSA_SEL_T 6'h20
`define RSA_IDX_E 3
`define RSA_IDX_A 4
`define RSA_IDX_MASK 6'h07
`define RSA_RND_MASK 6'h1f
// Bit positions and reset values
`define RSA_SIGN 23
`define RSA_GUARD 22
`define RSA_GR_RST 24'h000000
`define RSA_IRQ_DONE 0
`define RSA_IRQ_OVF 1
`endif

// [hw/rsa_pkg.sv]
// Types of the round/subtract unit
package rsa_pkg;
	typedef logic [23:0] rsa_word_t;
	typedef enum logic [3:0] {
		RSA_OP_ROUND = 4'h0,
		RSA_OP_SUB_MEM_IDX = 4'h1,
		RSA_OP_SUB_MEM_A = 4'h2,
		RSA_OP_SUB_MEM_E = 4'h3,
		RSA_OP_SUB_MEM_D = 4'h4,
		RSA_OP_SUB_MEM_B = 4'h5,
		RSA_OP_SUB_IMM_REG = 4'h6,
		RSA_OP_SUB_IMM_B = 4'h7,
		RSA_OP_SUB_REG = 4'h8
	} rsa_op_t;
	typedef enum logic [1:0] {
		RSA_ST_IDLE = 2'h0,
		RSA_ST_EXEC = 2'h1,
		RSA_ST_HIGH = 2'h2
	} rsa_st_t;
	typedef enum logic [1:0] {
		RSA_CC_ZERO = 2'h0,
		RSA_CC_POS = 2'h1,
		RSA_CC_NEG = 2'h2
	} rsa_cc_t;
endpackage

// [hw/rsa_unit.sv]
// Round and subtract datapath with APB register access
`include "rsa_defs.svh"

module rsa_unit (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output logic irq,
	output rsa_pkg::rsa_cc_t cc
);
	import rsa_pkg::*;

	////////////////////////////////////////////////////////////////
	// State
	rsa_word_t gr_ff [6]; // I,J,K,E,A,T in select order
	rsa_op_t op_ff; // Latched operation
	logic [5:0] r1_ff; // Source selects
	logic [5:0] r2_ff; // Destination selects
	rsa_word_t mem0_ff; // Word at effective address
	rsa_word_t mem1_ff; // Word at effective address plus one
	logic [14:0] imm_ff; // Immediate operand
	rsa_st_t st_ff;
	rsa_st_t nxt_st;
	rsa_cc_t cc_ff;
	logic ovf_ff;
	logic carry_ff; // Carry between double halves
	logic [1:0] ist_ff; // Sticky events
	logic [1:0] imsk_ff; // Event mask
	logic irq_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;

	////////////////////////////////////////////////////////////////
	// APB decode
	logic acc; // Access phase
	logic apb_wr; // Write takes effect this edge
	logic idle;
	logic cmd_wr;
	logic hit;
	logic [5:0] gr_wr;
	assign acc = psel & penable;
	assign apb_wr = acc & pwrite & pready_ff;
	assign idle = (st_ff == RSA_ST_IDLE);
	assign cmd_wr = apb_wr & (paddr == `RSA_OFF_CMD) & idle;

	// Address map check, also answers pslverr
	always_comb begin
		hit = 1'b0;
		if (paddr[1:0] != 2'h0) begin
			hit = 1'b0;
		end else if (paddr <= `RSA_OFF_IMSK) begin
			hit = 1'b1;
		end
	end

	// Per-register write strobes
	generate
		for (genvar g = 0; g < 6; g++) begin : g_wr
			assign gr_wr[g] = apb_wr & idle & (paddr == `RSA_OFF_GR0 + 12'(4 * g));
		end
	endgenerate

	// Answer one cycle into the access phase
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= acc & ~pready_ff;
			pslverr_ff <= acc & ~pready_ff & ~hit;
		end
	end

	////////////////////////////////////////////////////////////////
	// Operand selection
	logic [5:0] amask; // Registers ORed into minuend
	rsa_word_t a_or; // ORed minuend registers
	rsa_word_t s_or; // ORed source registers
	rsa_word_t opa;
	rsa_word_t opb;
	logic cin;
	logic [5:0] dmask; // Registers written by result
	logic bmode; // Byte register form
	logic dhigh; // High half of a double subtract
	logic [15:0] a_hi;
	assign a_hi = gr_ff[`RSA_IDX_A][23:8];
	assign dhigh = (st_ff == RSA_ST_HIGH);

	// OR of one-hot selections
	always_comb begin
		a_or = '0;
		s_or = '0;
		for (int i = 0; i < 6; i++) begin
			if (amask[i]) begin
				a_or = a_or | gr_ff[i];
			end
			if (r1_ff[i]) begin
				s_or = s_or | gr_ff[i];
			end
		end
	end

	// Subtraction is minuend + ~subtrahend + 1
	always_comb begin
		amask = r2_ff;
		opa = a_or;
		opb = ~s_or;
		cin = 1'b1;
		dmask = r2_ff;
		bmode = 1'b0;
		case (op_ff)
			RSA_OP_ROUND: begin
				// T is not a legal round source
				amask = r1_ff & `RSA_RND_MASK;
				opb = '0;
				cin = gr_ff[`RSA_IDX_A][`RSA_GUARD];
			end
			RSA_OP_SUB_MEM_IDX: begin
				// Operand already final, any indexing done upstream
				amask = r2_ff & `RSA_IDX_MASK;
				opb = ~mem0_ff;
				dmask = r2_ff & `RSA_IDX_MASK;
			end
			RSA_OP_SUB_MEM_A: begin
				amask = `RSA_SEL_A;
				opb = ~mem0_ff;
				dmask = `RSA_SEL_A;
			end
			RSA_OP_SUB_MEM_E: begin
				amask = `RSA_SEL_E;
				opb = ~mem0_ff;
				dmask = `RSA_SEL_E;
			end
			RSA_OP_SUB_MEM_D: begin
				// Low half first from the second word
				if (dhigh) begin
					amask = `RSA_SEL_E;
					opb = ~mem0_ff;
					cin = carry_ff;
					dmask = `RSA_SEL_E;
				end else begin
					// Bit 23 of low word not inverted: it only flips the carry
					amask = `RSA_SEL_A;
					opb = {mem1_ff[23], ~mem1_ff[22:0]};
					dmask = `RSA_SEL_A;
				end
			end
			RSA_OP_SUB_MEM_B: begin
				// Byte moved to the top so the sign logic is shared
				amask = 6'h00;
				opa = {gr_ff[`RSA_IDX_A][7:0], 16'h0000};
				opb = ~{mem0_ff[7:0], 16'h0000};
				dmask = `RSA_SEL_A;
				bmode = 1'b1;
			end
			RSA_OP_SUB_IMM_REG: begin
				opb = ~{9'h000, imm_ff};
			end
			RSA_OP_SUB_IMM_B: begin
				amask = 6'h00;
				opa = {gr_ff[`RSA_IDX_A][7:0], 16'h0000};
				opb = ~{imm_ff[7:0], 16'h0000};
				dmask = `RSA_SEL_A;
				bmode = 1'b1;
			end
			RSA_OP_SUB_REG: begin
				amask = r2_ff;
			end
			default: begin
				dmask = 6'h00;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Adder with split sign stage for overflow
	logic [23:0] low; // Bits 22-0 plus carry into sign
	logic [1:0] top; // Sign bit plus carry out
	rsa_word_t sum;
	rsa_word_t wval;
	logic ex_ovf;
	logic go; // Result written this edge
	logic fin; // Operation completes this edge
	assign low = {1'b0, opa[22:0]} + {1'b0, opb[22:0]} + {23'h0, cin};
	assign top = {1'b0, opa[23]} + {1'b0, opb[23]} + {1'b0, low[23]};
	assign sum = {top[0], low[22:0]};
	assign ex_ovf = low[23] ^ top[1];
	assign wval = bmode ? {a_hi, sum[23:16]} : sum;
	assign go = (st_ff == RSA_ST_EXEC) | dhigh;
	assign fin = dhigh | ((st_ff == RSA_ST_EXEC) & (op_ff != RSA_OP_SUB_MEM_D));

	// Result to every selected destination, others untouched
	generate
		for (genvar g = 0; g < 6; g++) begin : g_gr
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					gr_ff[g] <= `RSA_GR_RST;
				end else if (go && dmask[g]) begin
					gr_ff[g] <= wval;
				end else if (gr_wr[g]) begin
					gr_ff[g] <= pwdata[23:0];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Sequencer; commands while busy are dropped
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			RSA_ST_IDLE: begin
				if (cmd_wr) begin
					nxt_st = RSA_ST_EXEC;
				end
			end
			RSA_ST_EXEC: begin
				if (op_ff == RSA_OP_SUB_MEM_D) begin
					nxt_st = RSA_ST_HIGH;
				end else begin
					nxt_st = RSA_ST_IDLE;
				end
			end
			default: begin
				nxt_st = RSA_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_ff <= RSA_ST_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Command and operand latches
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			op_ff <= RSA_OP_ROUND;
			r1_ff <= 6'h00;
			r2_ff <= 6'h00;
		end else if (cmd_wr) begin
			op_ff <= rsa_op_t'(pwdata[`RSA_CMD_OP_LSB +: 4]);
			r1_ff <= pwdata[`RSA_CMD_R1_LSB +: 6];
			r2_ff <= pwdata[`RSA_CMD_R2_LSB +: 6];
		end
	end

	// Operands are frozen while busy so a run sees one set
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mem0_ff <= `RSA_GR_RST;
			mem1_ff <= `RSA_GR_RST;
			imm_ff <= 15'h0000;
		end else if (apb_wr && idle) begin
			if (paddr == `RSA_OFF_MEM0) begin
				mem0_ff <= pwdata[23:0];
			end else if (paddr == `RSA_OFF_MEM1) begin
				mem1_ff <= pwdata[23:0];
			end else if (paddr == `RSA_OFF_IMM) begin
				imm_ff <= pwdata[14:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Condition code, overflow and double carry
	logic res_zero;
	// Double result is zero only when both halves are
	assign res_zero = (sum == 24'h0) & (!dhigh || gr_ff[`RSA_IDX_A] == 24'h0);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cc_ff <= RSA_CC_ZERO;
			ovf_ff <= 1'b0;
		end else if (fin) begin
			ovf_ff <= ex_ovf;
			if (res_zero) begin
				cc_ff <= RSA_CC_ZERO;
			end else if (sum[`RSA_SIGN]) begin
				cc_ff <= RSA_CC_NEG;
			end else begin
				cc_ff <= RSA_CC_POS;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			carry_ff <= 1'b0;
		end else if (go && op_ff == RSA_OP_SUB_MEM_D && !dhigh) begin
			carry_ff <= sum[`RSA_SIGN]; // New A23
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupts: set beats a same-cycle write-one clear
	logic [1:0] ev;
	logic [1:0] nxt_ist;
	logic ist_clr;
	assign ev = {fin & ex_ovf, fin};
	assign ist_clr = apb_wr & (paddr == `RSA_OFF_IST);
	assign nxt_ist = (ist_ff & ~(ist_clr ? pwdata[1:0] : 2'h0)) | ev;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ist_ff <= 2'h0;
			imsk_ff <= 2'h0;
			irq_ff <= 1'b0;
		end else begin
			ist_ff <= nxt_ist;
			if (apb_wr && paddr == `RSA_OFF_IMSK) begin
				imsk_ff <= pwdata[1:0];
				irq_ff <= |(nxt_ist & pwdata[1:0]);
			end else begin
				irq_ff <= |(nxt_ist & imsk_ff);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Read data, loaded in the first access cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata_ff <= 32'h0;
		end else if (acc && !pready_ff) begin
			if (paddr == `RSA_OFF_CMD) begin
				prdata_ff <= {16'h0, r2_ff, r1_ff, op_ff};
			end else if (paddr == `RSA_OFF_MEM0) begin
				prdata_ff <= {8'h0, mem0_ff};
			end else if (paddr == `RSA_OFF_MEM1) begin
				prdata_ff <= {8'h0, mem1_ff};
			end else if (paddr == `RSA_OFF_IMM) begin
				prdata_ff <= {17'h0, imm_ff};
			end else if (paddr >= `RSA_OFF_GR0 && paddr <= `RSA_OFF_GR5 && hit) begin
				prdata_ff <= {8'h0, gr_ff[3'(paddr[4:2] - 3'h4)]};
			end else if (paddr == `RSA_OFF_FLAG) begin
				prdata_ff <= {27'h0, ~idle, carry_ff, ovf_ff, cc_ff};
			end else if (paddr == `RSA_OFF_IST) begin
				prdata_ff <= {30'h0, ist_ff};
			end else if (paddr == `RSA_OFF_IMSK) begin
				prdata_ff <= {30'h0, imsk_ff};
			end else begin
				prdata_ff <= 32'h0;
			end
		end
	end

	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign prdata = prdata_ff;
	assign irq = irq_ff;
	assign cc = cc_ff;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic ex1;
	rsa_word_t imm_w;
	assign ex1 = (st_ff == RSA_ST_EXEC);
	assign imm_w = {9'h000, imm_ff};

	a_round_incr: assert property (
		ex1 && op_ff == RSA_OP_ROUND && r1_ff == 6'h04 && r2_ff == 6'h01
		|=> gr_ff[0] == $past(gr_ff[2]) + {23'h0, $past(gr_ff[4][22])})
		else $error("round result wrong");
	a_round_keep: assert property (
		ex1 && op_ff == RSA_OP_ROUND && r1_ff[2] && !r2_ff[2] |=> $stable(gr_ff[2]))
		else $error("round source altered");
	a_round_no_t: assert property (
		ex1 && op_ff == RSA_OP_ROUND && r1_ff == 6'h20 && r2_ff == 6'h01
		|=> gr_ff[0] == {23'h0, $past(gr_ff[4][22])})
		else $error("T used as round source");
	a_multi_dest: assert property (
		ex1 && op_ff == RSA_OP_SUB_REG && r2_ff == 6'h03 |=> gr_ff[0] == gr_ff[1])
		else $error("destinations differ");
	a_cc_zero: assert property (
		ex1 && op_ff == RSA_OP_SUB_REG && r1_ff == r2_ff && r1_ff != 6'h0
		|=> cc_ff == RSA_CC_ZERO)
		else $error("zero result not flagged");
	a_ovf_set: assert property (
		ex1 && op_ff == RSA_OP_SUB_MEM_A && gr_ff[4] == 24'h800000 && mem0_ff == 24'h000001
		|=> ovf_ff && gr_ff[4] == 24'h7fffff)
		else $error("overflow missed");
	a_idx_sub: assert property (
		ex1 && op_ff == RSA_OP_SUB_MEM_IDX && r2_ff == 6'h02
		|=> gr_ff[1] == $past(gr_ff[1]) - $past(mem0_ff))
		else $error("index subtract wrong");
	a_acc_only: assert property (
		ex1 && op_ff == RSA_OP_SUB_MEM_A
		|=> $stable(gr_ff[3]) && gr_ff[4] == $past(gr_ff[4]) - $past(mem0_ff))
		else $error("accumulator subtract wrong");
	a_ext_sub: assert property (
		ex1 && op_ff == RSA_OP_SUB_MEM_E |=> gr_ff[3] == $past(gr_ff[3]) - $past(mem0_ff))
		else $error("extension subtract wrong");
	a_dbl_seq: assert property (
		ex1 && op_ff == RSA_OP_SUB_MEM_D |=> dhigh ##1 idle)
		else $error("double not two halves");
	a_dbl_carry: assert property (
		ex1 && op_ff == RSA_OP_SUB_MEM_D |=> carry_ff == gr_ff[4][23])
		else $error("carry not from A23");
	a_byte_keep: assert property (
		ex1 && op_ff == RSA_OP_SUB_MEM_B |=> $stable(a_hi))
		else $error("byte subtract touched A23-A8");
	a_imm_sub: assert property (
		ex1 && op_ff == RSA_OP_SUB_IMM_REG && r2_ff == 6'h04
		|=> gr_ff[2] == $past(gr_ff[2]) - $past(imm_w))
		else $error("immediate subtract wrong");
	a_imm_byte: assert property (
		ex1 && op_ff == RSA_OP_SUB_IMM_B |=> $stable(a_hi))
		else $error("immediate byte touched A23-A8");
	a_reg_sub: assert property (
		ex1 && op_ff == RSA_OP_SUB_REG && r1_ff == 6'h01 && r2_ff == 6'h02
		|=> gr_ff[1] == $past(gr_ff[1]) - $past(gr_ff[0]))
		else $error("register subtract wrong");

	c_round_up: cover property (ex1 && op_ff == RSA_OP_ROUND && gr_ff[4][22]);
	c_dbl_done: cover property (dhigh ##1 idle);
	c_irq: cover property (irq_ff);
endmodule

// [tb/rsa_apb_host.sv]
// Decoder-side APB requester that issues one transfer per request
module rsa_apb_host (
	input wire logic clk,
	input wire logic reset,
	input wire logic req,
	input wire logic req_wr,
	input wire logic [11:0] req_addr,
	input wire logic [31:0] req_wdata,
	output logic done = 1'b0,
	output logic [31:0] rdata = 32'h0,
	output logic err = 1'b0,
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [11:0] paddr = 12'h0,
	output logic [31:0] pwdata = 32'h0,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr
);
	////////////////////////////////////////////////////////////////
	// Setup, access until pready, then release with a done pulse
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			psel <= 1'b0;
			penable <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (psel && penable && pready) begin
				// Answer taken only at this edge
				psel <= 1'b0;
				penable <= 1'b0;
				done <= 1'b1;
				rdata <= prdata;
				err <= pslverr;
				// Released data lines must not look stable
				pwdata <= ~pwdata;
			end else if (psel) begin
				penable <= 1'b1;
			end else if (req && !done) begin
				// Done guard stops a second issue of a finished request
				psel <= 1'b1;
				pwrite <= req_wr;
				paddr <= req_addr;
				pwdata <= req_wdata;
			end
		end
	end
endmodule

// [tb/rsa_unit_tb.sv]
// Self-checking bench of the round and subtract unit
`include "rsa_defs.svh"
module rsa_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rsa_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, irq, done, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata, rd_v;
	rsa_cc_t cc;
	logic req = 1'b0;
	logic req_wr = 1'b0;
	logic [11:0] req_addr = 12'h0;
	logic [31:0] req_wdata = 32'h0;
	int n_errors = 0;
	int tests_run = 0;
	logic [31:0] seed = 32'hfd63;
	// Shadow of the six general registers
	rsa_word_t g [6];
	logic e_ovf;
	rsa_cc_t e_cc;
	rsa_word_t mem1_v = 24'h1; // Low word of the double tests, kept for prediction
	always #25 clk = ~clk;
	rsa_apb_host rsa_apb_host_inst (.clk(clk), .reset(reset), .req(req), .req_wr(req_wr),
		.req_addr(req_addr), .req_wdata(req_wdata), .done(done), .rdata(rdata), .err(err),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr));
	rsa_unit rsa_unit_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .irq(irq), .cc(cc));
	////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Two's complement difference with overflow in the top bit
	function automatic logic [24:0] sub24(rsa_word_t a, rsa_word_t b);
		rsa_word_t d;
		d = a - b;
		return {(a[23] != b[23]) && (d[23] != a[23]), d};
	endfunction
	function automatic logic [8:0] sub8(logic [7:0] a, logic [7:0] b);
		logic [7:0] d;
		d = a - b;
		return {(a[7] != b[7]) && (d[7] != a[7]), d};
	endfunction
	function automatic rsa_cc_t ccof(rsa_word_t v);
		return (v == 24'h0) ? RSA_CC_ZERO : (v[23] ? RSA_CC_NEG : RSA_CC_POS);
	endfunction
	// Selected registers ORed together
	function automatic rsa_word_t orsel(logic [5:0] s);
		rsa_word_t v;
		v = 24'h0;
		for (int i = 0; i < 6; i++) if (s[i]) v = v | g[i];
		return v;
	endfunction
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, seen);
			n_errors++;
		end
	endtask
	// One APB transfer, held until the host reports completion
	task automatic bus(logic wr, logic [11:0] a, logic [31:0] d);
		int k;
		@(posedge clk);
		req <= 1'b1;
		req_wr <= wr;
		req_addr <= a;
		req_wdata <= d;
		for (k = 0; k < 20 && done !== 1'b1; k++) @(posedge clk);
		req <= 1'b0;
		rd_v = rdata;
		if (k == 20) begin
			n_errors++;
			summarize();
		end
	endtask
	task automatic setreg(int i, rsa_word_t v);
		bus(1'b1, `RSA_OFF_GR0 + 12'(4 * i), {8'h0, v});
		g[i] = v;
	endtask
	////////////////////////////////////////////////////////////////
	// Launch one operation, predict it, compare flags and the six general registers
	task automatic doop(logic [3:0] o, logic [5:0] r1, logic [5:0] r2, rsa_word_t m0,
		logic [14:0] imm);
		logic [24:0] t;
		logic [8:0] b;
		logic [5:0] dst;
		int k;
		rsa_word_t src;
		logic [24:0] s;
		logic cy;
		bus(1'b1, `RSA_OFF_MEM0, {8'h0, m0});
		bus(1'b1, `RSA_OFF_IMM, {17'h0, imm});
		bus(1'b1, `RSA_OFF_CMD, {16'h0, r2, r1, o});
		dst = 6'h0;
		b = 9'h0;
		case (o)
			4'h0: begin
				// Guard bit A22 is the carry in; T is never a source
				src = orsel(r1 & `RSA_RND_MASK);
				t[23:0] = src + {23'h0, g[`RSA_IDX_A][22]};
				// Only a carry into a clear sign bit can overflow
				t[24] = !src[23] && t[23];
				dst = r2;
			end
			4'h1: begin
				dst = r2 & `RSA_IDX_MASK;
				t = sub24(orsel(dst), m0);
			end
			4'h2: begin
				dst = `RSA_SEL_A;
				t = sub24(g[`RSA_IDX_A], m0);
			end
			4'h3: begin
				dst = `RSA_SEL_E;
				t = sub24(g[`RSA_IDX_E], m0);
			end
			4'h4: begin
				// Low word first; new A23 holds the no-borrow for the high half
				cy = (g[`RSA_IDX_A][22:0] >= mem1_v[22:0]);
				g[`RSA_IDX_A] = {cy, 23'(g[`RSA_IDX_A][22:0] - mem1_v[22:0])};
				s = {g[`RSA_IDX_E][23], g[`RSA_IDX_E]} - {m0[23], m0} - {24'h0, !cy};
				dst = `RSA_SEL_E;
				t = {s[24] != s[23], s[23:0]};
			end
			4'h5: b = sub8(g[`RSA_IDX_A][7:0], m0[7:0]);
			4'h6: begin
				dst = r2;
				t = sub24(orsel(r2), {9'h0, imm});
			end
			4'h7: b = sub8(g[`RSA_IDX_A][7:0], imm[7:0]);
			default: begin
				dst = r2;
				t = sub24(orsel(r2), orsel(r1));
			end
		endcase
		if (o == 4'h5 || o == 4'h7) begin
			g[`RSA_IDX_A][7:0] = b[7:0];
			e_ovf = b[8];
			e_cc = ccof({{16{b[7]}}, b[7:0]});
		end else begin
			for (int i = 0; i < 6; i++) if (dst[i]) g[i] = t[23:0];
			e_ovf = t[24];
			e_cc = ccof(t[23:0]);
			// Double result is zero only when both halves are
			if (o == 4'h4 && t[23:0] == 24'h0 && g[`RSA_IDX_A] != 24'h0) e_cc = RSA_CC_POS;
		end
		for (k = 0; k < 20; k++) begin
			bus(1'b0, `RSA_OFF_FLAG, 32'h0);
			if (rd_v[4] === 1'b0) break;
		end
		chk("busy", {31'h0, rd_v[4]}, 32'h0);
		if (k == 20) summarize();
		chk("flag_ovf", {31'h0, rd_v[2]}, {31'h0, e_ovf});
		chk("flag_cc", {30'h0, rd_v[1:0]}, {30'h0, e_cc});
		chk("cc_port", {30'h0, cc}, {30'h0, e_cc});
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, `RSA_OFF_GR0 + 12'(4 * i), 32'h0);
			chk("reg", rd_v, {8'h0, g[i]});
		end
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [3:0] o;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, `RSA_OFF_GR0 + 12'(4 * i), 32'h0);
			chk("reg_rst", rd_v, {8'h0, `RSA_GR_RST});
		end
		chk("irq_rst", {31'h0, irq}, 32'h0);
		$display("test reset done");
		// Unmapped and unaligned places answer with an error and zero
		bus(1'b0, 12'h100, 32'h0);
		chk("err_unmapped", {31'h0, err}, 32'h1);
		chk("rd_unmapped", rd_v, 32'h0);
		bus(1'b1, 12'h012, 32'h5);
		chk("err_unaligned", {31'h0, err}, 32'h1);
		$display("test decode done");
		// Round of K into A with guard set, then of K into J and K with guard clear
		setreg(2, 24'h7fffff);
		setreg(4, 24'h400000);
		doop(4'h0, `RSA_SEL_K, `RSA_SEL_A, 24'h0, 15'h0);
		doop(4'h0, `RSA_SEL_K | `RSA_SEL_T, `RSA_SEL_J | `RSA_SEL_K, 24'h0, 15'h0);
		doop(4'h8, `RSA_SEL_I, `RSA_SEL_J, 24'h0, 15'h0);
		doop(4'h0, `RSA_SEL_K, `RSA_SEL_I, 24'h0, 15'h0);
		doop(4'h0, `RSA_SEL_T, `RSA_SEL_I, 24'h0, 15'h0);
		doop(4'h8, `RSA_SEL_K, `RSA_SEL_I | `RSA_SEL_J, 24'h0, 15'h0);
		doop(4'h8, `RSA_SEL_J, `RSA_SEL_J, 24'h0, 15'h0);
		doop(4'h1, 6'h0, `RSA_SEL_J, 24'h3, 15'h0);
		doop(4'h6, 6'h0, `RSA_SEL_K, 24'h0, 15'h7fff);
		$display("test round done");
		// Double subtract without and with a carry across the halves
		setreg(4, 24'h000000);
		setreg(3, 24'h000005);
		bus(1'b1, `RSA_OFF_MEM1, {8'h0, mem1_v});
		doop(4'h4, 6'h0, 6'h0, 24'h2, 15'h0);
		bus(1'b0, `RSA_OFF_GR0 + 12'(4 * `RSA_IDX_E), 32'h0);
		chk("dbl_hi", rd_v, 32'h2);
		bus(1'b0, `RSA_OFF_GR0 + 12'(4 * `RSA_IDX_A), 32'h0);
		chk("dbl_lo", {9'h0, rd_v[22:0]}, 32'h7fffff);
		setreg(4, 24'h000003);
		setreg(3, 24'h000005);
		doop(4'h4, 6'h0, 6'h0, 24'h2, 15'h0);
		bus(1'b0, `RSA_OFF_FLAG, 32'h0);
		chk("dbl_carry", {31'h0, rd_v[3]}, 32'h1);
		bus(1'b0, `RSA_OFF_GR0 + 12'(4 * `RSA_IDX_E), 32'h0);
		chk("dbl_hi_c", rd_v, 32'h3);
		$display("test double done");
		// Random operations of every single-length kind
		for (int i = 0; i < 6; i++) setreg(i, 24'(rnd()));
		for (int n = 0; n < 45; n++) begin
			o = 4'(rnd() % 9);
			if (o == 4'h4) o = 4'h8;
			doop(o, 6'(rnd()), 6'(rnd()), 24'(rnd()), 15'(rnd()));
		end
		$display("test random done");
		// Done event: sticky, masked, then raised and cleared
		bus(1'b1, `RSA_OFF_IMSK, 32'h0);
		bus(1'b1, `RSA_OFF_IST, 32'h3);
		// Most negative minus one overflows and raises the second event
		setreg(4, 24'h800000);
		doop(4'h2, 6'h0, 6'h0, 24'h1, 15'h0);
		bus(1'b0, `RSA_OFF_IST, 32'h0);
		chk("ist_done", {31'h0, rd_v[`RSA_IRQ_DONE]}, 32'h1);
		chk("ist_ovf", {31'h0, rd_v[`RSA_IRQ_OVF]}, 32'h1);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		bus(1'b1, `RSA_OFF_IMSK, 32'h1);
		bus(1'b0, `RSA_OFF_IMSK, 32'h0);
		chk("irq_on", {31'h0, irq}, 32'h1);
		bus(1'b1, `RSA_OFF_IST, 32'h1);
		bus(1'b0, `RSA_OFF_IST, 32'h0);
		chk("ist_clr", {31'h0, rd_v[`RSA_IRQ_DONE]}, 32'h0);
		chk("irq_off", {31'h0, irq}, 32'h0);
		$display("test interrupt done");
		summarize();
	end
endmodule
